// ==== bench/sr_host_model.sv ====
// host side model: shifts bytes msb first, pulses the latch clock
`timescale 1ns/1ps
`default_nettype none
module sr_host_model (
  input wire logic i_mclk,
  output logic o_shift_clock, o_latch_clock, o_serial_in
);
  initial {o_shift_clock, o_latch_clock, o_serial_in} = 3'h0;
  // 4 low, 4 high = 320 ns; clock idles low between frames, data shows its inverse
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_mclk) o_serial_in <= b[i];
      repeat (3) @(posedge i_mclk);
      o_shift_clock <= 1'b1;
      repeat (4) @(posedge i_mclk);
      o_shift_clock <= 1'b0;
    end
    o_serial_in <= ~b[0];
  endtask
  task automatic pulse();
    @(posedge i_mclk) o_latch_clock <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_latch_clock <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule // sr_host_model
`default_nettype wire

// ==== bench/sr_sink_driver_checker.sv ====
// concurrent checks on the sink driver ports
`timescale 1ns/1ps
`default_nettype none
module sr_sink_driver_checker #(parameter int FIFO_DEPTH = 8) (
  input wire logic i_mclk, i_resetn, i_shift_clock, i_latch_clock, i_serial_in,
  input wire logic i_shift_clear_n, i_output_enable_n, o_cascade_out, o_latch_ready,
  input wire logic [sr_pkg::SR_WIDTH-1:0] o_sink_out, o_sink_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  a_sink_low: assert property (o_sink_out == 8'h00) else $error("sink pin high");
  a_oe_disabled: assert property (i_output_enable_n |-> ##3 o_sink_oe == 8'h00) else $error("on while off");
  a_oe_clear: assert property (!i_shift_clear_n |-> ##3 o_sink_oe == 8'h00) else $error("on in clear");
  a_chain_clear: assert property (!i_shift_clear_n |-> ##3 !o_cascade_out) else $error("chain kept");
  a_oe_cause: assert property (o_sink_oe != 8'h00 |->
    !$past(i_output_enable_n, 3) && $past(i_shift_clear_n, 3)) else $error("on unasked");
  a_cascade_cause: assert property ($changed(o_cascade_out) |->
    $past(i_shift_clock, 3) && !$past(i_shift_clock, 4) || !$past(i_shift_clear_n, 3)) else $error("cascade moved");
  a_oe_steady: assert property ((!i_output_enable_n && i_shift_clear_n && !i_latch_clock) [*8] |=>
    $stable(o_sink_oe)) else $error("sinks moved");
  a_ready_idle: assert property ((i_shift_clear_n && !i_latch_clock) [*8] |=> o_latch_ready)
    else $error("fifo stuck");
endmodule // sr_sink_driver_checker
bind sr_sink_driver sr_sink_driver_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);
`default_nettype wire

// ==== bench/sr_sink_driver_test.sv ====
// self-checking bench for the latched sink driver
`timescale 1ns/1ps
`default_nettype none
module sr_sink_driver_test;
  logic i_mclk = 1'b0, i_resetn = 1'b0, i_shift_clear_n = 1'b1, i_output_enable_n = 1'b0;
  wire logic i_shift_clock, i_latch_clock, i_serial_in, o_cascade_out, o_latch_ready;
  wire logic [7:0] o_sink_out, o_sink_oe;
  int miscompares = 0, cmp_count = 0;
  initial forever #20 i_mclk = ~i_mclk;
  // depth 2 so a few latch edges in clear fill the fifo
  sr_sink_driver #(.FIFO_DEPTH(2)) u_sr_sink_driver (.*);
  sr_host_model u_sr_host_model (.i_mclk, .o_shift_clock(i_shift_clock), .o_latch_clock(i_latch_clock),
    .o_serial_in(i_serial_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic t_load();
    u_sr_host_model.send(8'hA5);
    u_sr_host_model.pulse();
    repeat (6) @(negedge i_mclk);
    chk(o_sink_oe, 8'hA5);
    chk(o_sink_out, 8'h00);
    chk(8'(o_cascade_out), 8'h01);
    @(posedge i_mclk) i_output_enable_n <= 1'b1;
    repeat (5) @(negedge i_mclk);
    chk(o_sink_oe, 8'h00);
    @(posedge i_mclk) i_output_enable_n <= 1'b0;
    $display("t_load end");
  endtask
  task automatic t_casc();
    u_sr_host_model.send(8'h3C);
    u_sr_host_model.pulse();
    repeat (2) @(negedge i_mclk);
    chk(8'(o_cascade_out), 8'h00);
    chk(o_sink_oe, 8'h3C);
    $display("t_casc end");
  endtask
  task automatic t_clear();
    @(posedge i_mclk) i_shift_clear_n <= 1'b0;
    repeat (5) @(negedge i_mclk);
    chk(o_sink_oe, 8'h00);
    chk(8'(o_cascade_out), 8'h00);
    repeat (3) u_sr_host_model.pulse();
    @(negedge i_mclk);
    chk(8'(o_latch_ready), 8'h00);
    @(posedge i_mclk) i_shift_clear_n <= 1'b1;
    repeat (8) @(negedge i_mclk);
    chk(8'(o_latch_ready), 8'h01);
    chk(o_sink_oe, 8'h00);
    $display("t_clear end");
  endtask
  task automatic end_of_test();
    $display("cmp %0d bad %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_load();
    t_casc();
    t_clear();
    end_of_test();
  end
  initial #200_000 begin
    miscompares++;
    end_of_test();
  end
endmodule // sr_sink_driver_test
`default_nettype wire

// ==== verilog/sr_pkg.sv ====
// shared constants and carrier types of the latched sink driver
package sr_pkg;
  localparam int SR_WIDTH = 8;
  localparam int SR_FIFO_DEPTH = 8;
  localparam logic [7:0] SR_SHIFT_RESET = 8'h00;
  localparam logic [7:0] SR_LATCH_RESET = 8'h00;
  localparam logic [7:0] SR_SINK_OFF = 8'h00;
  localparam logic [4:0] SR_PINS_RESET = 5'h00;
  // pin idle image after reset: clears and enables read inactive (high)
  localparam logic [4:0] SR_PINS_IDLE = 5'h18;

  typedef struct packed {
    logic output_enable_n;
    logic shift_clear_n;
    logic serial_in;
    logic latch_clock;
    logic shift_clock;
  } sr_pins_t;
endpackage : sr_pkg

// ==== verilog/sr_sink_driver.sv ====
// serial-in latched sink driver with snapshot fifo between shift chain and storage latch
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - eight-stage shift chain feeds eight-bit storage latch
// - shift clock rise captures input, advances chain
// - latch clock rise copies chain into latch
// - clear low zeroes chain, latch keeps contents
// - latch reaches buffer only while clear high
// - enable high forces every buffer bit low
// - enable low, buffer follows storage latch
// - buffer bit zero turns sink off
// - buffer bit one sinks toward ground
// - chain data presented on cascade output

module sr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  wire logic push;
  wire logic pop;
  wire logic [PTR_W-1:0] wr_ptr_next;
  wire logic [PTR_W-1:0] rd_ptr_next;

  assign o_in_ready = (count_reg != CNT_FULL);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
  assign rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // storage array carries no reset; only pointers and count matter
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_next;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_next;
      end
      count_reg <= count_next;
    end
  end
endmodule // sr_fifo

module sr_sink_driver #(
  parameter int FIFO_DEPTH = sr_pkg::SR_FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_shift_clock,
  input wire logic i_latch_clock,
  input wire logic i_serial_in,
  input wire logic i_shift_clear_n,
  input wire logic i_output_enable_n,
  output logic o_cascade_out,
  output logic [sr_pkg::SR_WIDTH-1:0] o_sink_out,
  output logic [sr_pkg::SR_WIDTH-1:0] o_sink_oe,
  output logic o_latch_ready
);
  import sr_pkg::*;

  // pin synchronisers: stage 1 is read only by stage 2
  sr_pins_t pins_raw;
  sr_pins_t sync1_reg;
  sr_pins_t sync2_reg;
  sr_pins_t sync3_reg;

  logic [SR_WIDTH-1:0] shift_reg;
  logic [SR_WIDTH-1:0] shift_next;
  logic [SR_WIDTH-1:0] latch_reg;
  logic [SR_WIDTH-1:0] sink_oe_reg;
  logic [SR_WIDTH-1:0] sink_oe_next;
  logic [SR_WIDTH-1:0] sink_out_reg;
  logic cascade_reg;
  logic latch_ready_reg;

  wire logic shift_rise;
  wire logic latch_rise;
  wire logic clear_active;
  wire logic outputs_enabled;
  wire logic snap_ready;
  wire logic snap_valid;
  wire logic [SR_WIDTH-1:0] snap_data;
  wire logic load_latch;

  assign pins_raw.shift_clock = i_shift_clock;
  assign pins_raw.latch_clock = i_latch_clock;
  assign pins_raw.serial_in = i_serial_in;
  assign pins_raw.shift_clear_n = i_shift_clear_n;
  assign pins_raw.output_enable_n = i_output_enable_n;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= SR_PINS_IDLE;
      sync2_reg <= SR_PINS_IDLE;
      sync3_reg <= SR_PINS_IDLE;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // edges found on stages 2 and 3, never on stage 1
  assign shift_rise = sync2_reg.shift_clock && !sync3_reg.shift_clock;
  assign latch_rise = sync2_reg.latch_clock && !sync3_reg.latch_clock;
  assign clear_active = !sync2_reg.shift_clear_n;
  assign outputs_enabled = !sync2_reg.output_enable_n;

  // clear overrides a coincident shift edge
  always_comb begin
    shift_next = shift_reg;
    if (clear_active) begin
      shift_next = SR_SHIFT_RESET;
    end else if (shift_rise) begin
      shift_next = {shift_reg[SR_WIDTH-2:0], sync2_reg.serial_in};
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_reg <= SR_SHIFT_RESET;
      cascade_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cascade_reg <= shift_next[SR_WIDTH-1];
    end
  end

  // a latch edge snapshots the chain; the fifo absorbs edges while the latch is held
  assign load_latch = snap_valid && !clear_active;

  sr_fifo #(
    .WIDTH(SR_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_snap_fifo (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_in_valid(latch_rise),
    .o_in_ready(snap_ready),
    .i_in_data(shift_reg),
    .o_out_valid(snap_valid),
    .i_out_ready(!clear_active),
    .o_out_data(snap_data)
  );

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_reg <= SR_LATCH_RESET;
    end else if (load_latch) begin
      latch_reg <= snap_data;
    end
  end

  // buffer sees the latch only when enabled and not clearing
  wire logic buffer_open;
  assign buffer_open = outputs_enabled && !clear_active;

  // one select per sink, so a stuck bit cannot bleed into its neighbours
  for (genvar g = 0; g < SR_WIDTH; g++) begin : g_sink
    assign sink_oe_next[g] = buffer_open ? latch_reg[g] : SR_SINK_OFF[g];
  end

  // open drain: the pin value is always low, the enable decides sinking
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sink_oe_reg <= SR_SINK_OFF;
      sink_out_reg <= SR_SINK_OFF;
      latch_ready_reg <= 1'b0;
    end else begin
      sink_oe_reg <= sink_oe_next;
      sink_out_reg <= SR_SINK_OFF;
      latch_ready_reg <= snap_ready;
    end
  end

  assign o_cascade_out = cascade_reg;
  assign o_sink_oe = sink_oe_reg;
  assign o_sink_out = sink_out_reg;
  assign o_latch_ready = latch_ready_reg;
endmodule // sr_sink_driver

`default_nettype wire
